/* rtl/stbs_bus_if.sv */
// Purpose: Shared bus wires between target end and initiator end
// Assumes: Open-drain style: an enable low pulls the line low (asserted)
// Notes:   Wire level is the AND of all drivers; high when released
`timescale 1ns/1ps
interface stbs_bus_if;
    // Target side drives
    logic       t_bsy_oe_n;
    logic       t_sel_oe_n;
    logic       t_cd_oe_n;
    logic       t_io_oe_n;
    logic       t_msg_oe_n;
    logic       t_req_oe_n;
    logic       t_rst_oe_n;
    logic [7:0] t_db_oe_n;
    logic       t_dbp_oe_n;
    // Initiator side drives
    logic       i_bsy_oe_n;
    logic       i_sel_oe_n;
    logic       i_ack_oe_n;
    logic       i_atn_oe_n;
    logic       i_rst_oe_n;
    logic [7:0] i_db_oe_n;
    logic       i_dbp_oe_n;
    // Resolved electrical levels (low = true)
    logic       bsy_n;
    logic       sel_n;
    logic       cd_n;
    logic       io_n;
    logic       msg_n;
    logic       req_n;
    logic       ack_n;
    logic       atn_n;
    logic       rst_n;
    logic [7:0] db_n;
    logic       dbp_n;

    assign bsy_n = t_bsy_oe_n & i_bsy_oe_n;
    assign sel_n = t_sel_oe_n & i_sel_oe_n;
    assign cd_n  = t_cd_oe_n;
    assign io_n  = t_io_oe_n;
    assign msg_n = t_msg_oe_n;
    assign req_n = t_req_oe_n;
    assign ack_n = i_ack_oe_n;
    assign atn_n = i_atn_oe_n;
    assign rst_n = t_rst_oe_n & i_rst_oe_n;
    assign db_n  = t_db_oe_n & i_db_oe_n;
    assign dbp_n = t_dbp_oe_n & i_dbp_oe_n;

    modport target (
        output t_bsy_oe_n, t_sel_oe_n, t_cd_oe_n, t_io_oe_n, t_msg_oe_n,
        output t_req_oe_n, t_rst_oe_n, t_db_oe_n, t_dbp_oe_n,
        input  bsy_n, sel_n, ack_n, atn_n, rst_n, db_n, dbp_n
    );
    modport initiator (
        output i_bsy_oe_n, i_sel_oe_n, i_ack_oe_n, i_atn_oe_n,
        output i_rst_oe_n, i_db_oe_n, i_dbp_oe_n,
        input  bsy_n, sel_n, cd_n, io_n, msg_n, req_n, rst_n, db_n, dbp_n
    );
endinterface

/* rtl/stbs_defines.svh */
// Purpose: Constants for the parallel target bus port
// Assumes: Bus lines are active low at the pins
// Notes:   Counts are in core clock cycles
`ifndef STBS_DEFINES_SVH
`define STBS_DEFINES_SVH
`define STBS_DATA_W      8
`define STBS_MAX_DEV     8
`define STBS_ID_W        3
`define STBS_BUF_DEPTH   2
`define STBS_SYNC_STAGES 2
`endif

/* rtl/stbs_initiator.sv */
// Purpose: Initiator end: selects a target and answers REQ with ACK
// Assumes: One core clock; bus lines asynchronous to it
// Notes:   No arbitration; caller guarantees it owns the bus
`timescale 1ns/1ps
`include "stbs_defines.svh"
module stbs_initiator #(
    parameter logic [`STBS_ID_W-1:0] OWN_ID = 3'h7
) (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst_n,
    stbs_bus_if.initiator                 bus,
    input  wire logic                     i_select,
    input  wire stbs_pkg::stbs_id_t       i_target_id,
    input  wire logic                     i_atn,
    input  wire logic                     i_bus_reset,
    input  wire stbs_pkg::stbs_byte_t     i_tx_data,
    output logic                          o_tx_ready,
    output stbs_pkg::stbs_byte_t          o_rx_data,
    output logic                          o_rx_valid,
    output logic                          o_rx_par_err,
    output logic                          o_connected
);
    typedef enum {SI_IDLE, SI_SEL, SI_CONN, SI_ACK} stbs_istate_t;

    typedef struct packed {
        logic [13:0]          s1;
        logic [13:0]          s2;
        stbs_istate_t         st;
        logic                 sel;
        logic                 ack;
        logic                 drive;
        stbs_pkg::stbs_byte_t dout;
        stbs_pkg::stbs_byte_t rx;
        logic                 rx_v;
        logic                 perr;
        logic                 tx_rdy;
        logic                 conn;
    } stbs_ini_t;

    stbs_ini_t q, d;

    logic [13:0] raw;
    assign raw = ~{bus.bsy_n, bus.req_n, bus.io_n, bus.rst_n, bus.sel_n,
                   bus.dbp_n, bus.db_n};
    logic                 b_bsy, b_req, b_io, b_rst, b_sel, b_par;
    stbs_pkg::stbs_byte_t b_db;
    assign {b_bsy, b_req, b_io, b_rst, b_sel, b_par, b_db} = q.s2;

    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.rx_v = 1'b0;
        d.tx_rdy = 1'b0;
        case (q.st)
            SI_IDLE: begin
                if (i_select && !b_bsy && !b_sel) begin
                    d.sel = 1'b1;
                    d.dout = (8'h01 << OWN_ID) | (8'h01 << i_target_id);
                    d.drive = 1'b1;
                    d.st = SI_SEL;
                end
            end
            SI_SEL: if (b_bsy) begin
                d.sel = 1'b0;
                d.drive = 1'b0;
                d.st = SI_CONN;
            end
            SI_CONN: begin
                if (!b_bsy) begin
                    d.st = SI_IDLE;
                end else if (b_req) begin
                    if (b_io) begin
                        d.rx = b_db;
                        d.perr = (~(^b_db)) != b_par;
                        d.rx_v = 1'b1;
                    end else begin
                        d.dout = i_tx_data;
                        d.drive = 1'b1;
                        d.tx_rdy = 1'b1;
                    end
                    d.ack = 1'b1;
                    d.st = SI_ACK;
                end
            end
            SI_ACK: if (!b_req) begin
                d.ack = 1'b0;
                d.drive = 1'b0;
                d.st = SI_CONN;
            end
            default: d.st = SI_IDLE;
        endcase
        if (b_rst) begin
            d.st = SI_IDLE;
            d.sel = 1'b0;
            d.ack = 1'b0;
            d.drive = 1'b0;
        end
        d.conn = (d.st == SI_CONN) || (d.st == SI_ACK);
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
            q.st <= SI_IDLE;
        end else begin
            q <= d;
        end
    end

    assign bus.i_bsy_oe_n = 1'b1;
    assign bus.i_sel_oe_n = ~q.sel;
    assign bus.i_ack_oe_n = ~q.ack;
    assign bus.i_atn_oe_n = ~(i_atn && q.st != SI_IDLE);
    assign bus.i_rst_oe_n = ~i_bus_reset;
    assign bus.i_db_oe_n  = q.drive ? ~q.dout : 8'hFF;
    assign bus.i_dbp_oe_n = ~(q.drive && ~(^q.dout));

    assign o_tx_ready   = q.tx_rdy;
    assign o_rx_data    = q.rx;
    assign o_rx_valid   = q.rx_v;
    assign o_rx_par_err = q.perr;
    assign o_connected  = q.conn;
endmodule

/* rtl/stbs_pkg.sv */
// Purpose: Types for the parallel target bus port
// Assumes: Used as stbs_pkg::name, never imported
// Notes:   Phase encodes msg, cd, io in that bit order
package stbs_pkg;
    typedef logic [7:0] stbs_byte_t;
    typedef logic [2:0] stbs_id_t;
    typedef logic [2:0] stbs_phase_t;
endpackage

/* rtl/stbs_target.sv */
// Purpose: Target end of the eight-bit parallel bus: selection and REQ/ACK
// Assumes: One core clock; bus lines asynchronous to it
// Notes:   Phase sequencing is supplied by the user through i_phase
//
// Behaviour
// - Only two devices talk; others stay passive
// - At most eight devices on the bus
// - Identifier n maps to data line n
// - Busy is wired-OR; true means bus in use
// - Select is wired-OR, initiator or reselecting target; this target never drives select (t_sel_oe_n tied high)
// - Target alone drives control/data direction line
// - Message line asserted only in message phase
// - Target starts each transfer by asserting request
// - Initiator answers each request with acknowledge
// - Initiator drives attention; target monitors it
// - Reset line wired-OR; both recognise it
// - Line 7 most significant, highest priority
// - Asserted line reads as logic one
// - Odd parity, unchecked during arbitration
// - All lines active low; invert at pins
`timescale 1ns/1ps
`include "stbs_defines.svh"
module stbs_target #(
    parameter logic [`STBS_ID_W-1:0] OWN_ID = 3'h5
) (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst_n,
    stbs_bus_if.target                    bus,
    input  wire stbs_pkg::stbs_phase_t    i_phase,
    input  wire logic                     i_connect,
    input  wire stbs_pkg::stbs_byte_t     i_tx_data,
    input  wire logic                     i_tx_valid,
    output logic                          o_tx_ready,
    output stbs_pkg::stbs_byte_t          o_rx_data,
    output logic                          o_rx_valid,
    input  wire logic                     i_rx_ready,
    output logic                          o_rx_par_err,
    output logic                          o_selected,
    output logic                          o_atn,
    output logic                          o_bus_rst,
    output logic                          o_bus_busy
);
    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    localparam int BD = `STBS_BUF_DEPTH;

    typedef enum {ST_IDLE, ST_SEL, ST_REQ, ST_ACK} stbs_tstate_t;

    typedef struct packed {
        logic [13:0]          s1;
        logic [13:0]          s2;
        stbs_tstate_t         st;
        logic                 sel;
        logic                 req;
        logic                 bsy;
        logic                 par_err;
        stbs_pkg::stbs_byte_t dout;
        logic                 tx_ready;
        stbs_pkg::stbs_byte_t buf0;
        stbs_pkg::stbs_byte_t buf1;
        logic [1:0]           cnt;
        logic                 rx_v;
    } stbs_tgt_t;

    stbs_tgt_t q, d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Odd parity bit for a byte
    function automatic logic odd_par(input stbs_pkg::stbs_byte_t b);
        odd_par = ~(^b);
    endfunction

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    // Active-low bus vector in, synchronised bus level out
    logic [13:0] raw;
    assign raw = ~{bus.bsy_n, bus.sel_n, bus.ack_n, bus.atn_n,
                   bus.rst_n, bus.dbp_n, bus.db_n};

    logic                 b_bsy, b_sel, b_ack, b_atn, b_rst, b_par;
    stbs_pkg::stbs_byte_t b_db;
    assign {b_bsy, b_sel, b_ack, b_atn, b_rst, b_par, b_db} = q.s2;

    logic to_init;
    assign to_init = i_phase[0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        case (q.st)
            ST_IDLE: begin
                d.bsy = 1'b0;
                // Own ID bit on the data lines with select true
                if (b_sel && !b_bsy && b_db[OWN_ID] && i_connect) begin
                    d.st = ST_SEL;
                end
            end
            ST_SEL: begin
                d.bsy = 1'b1;
                if (!b_sel) begin
                    d.st = ST_REQ;
                end
            end
            ST_REQ: begin
                if (!i_connect) begin
                    d.st = ST_IDLE;
                    d.bsy = 1'b0;
                end else if (to_init && q.cnt != 2'h0) begin
                    d.dout = q.buf0;
                    d.req = 1'b1;
                    d.st = ST_ACK;
                end else if (!to_init && !b_ack && q.cnt != 2'(BD)) begin
                    d.req = 1'b1;
                    d.st = ST_ACK;
                end
            end
            ST_ACK: begin
                if (q.req && b_ack) begin
                    d.req = 1'b0;
                    if (to_init) begin
                        d.buf0 = q.buf1;
                        d.cnt = q.cnt - 2'h1;
                    end else begin
                        d.par_err = (odd_par(b_db) != b_par);
                        if (q.cnt == 2'h0) begin
                            d.buf0 = b_db;
                        end else begin
                            d.buf1 = b_db;
                        end
                        d.cnt = q.cnt + 2'h1;
                    end
                end else if (!q.req && !b_ack) begin
                    d.st = ST_REQ;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        // --------------------------------------------------------
        // Buffer
        // --------------------------------------------------------
        // Two-entry buffer: user side fills (to initiator) or drains
        if (to_init) begin
            if (i_tx_valid && q.tx_ready && d.cnt != 2'(BD)) begin
                if (d.cnt == 2'h0) d.buf0 = i_tx_data;
                else d.buf1 = i_tx_data;
                d.cnt = d.cnt + 2'h1;
            end
        end else if (i_rx_ready && q.rx_v && d.cnt != 2'h0) begin
            d.buf0 = d.buf1;
            d.cnt = d.cnt - 2'h1;
        end
        d.tx_ready = to_init && (d.cnt != 2'(BD));
        if (b_rst) begin
            d.st = ST_IDLE;
            d.req = 1'b0;
            d.bsy = 1'b0;
            d.cnt = 2'h0;
            d.tx_ready = 1'b0;
        end
        d.rx_v = !to_init && (d.cnt != 2'h0);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Bus drivers
    // ------------------------------------------------------------
    // Drivers stay released unless this target holds the bus
    logic own;
    assign own = (q.st != ST_IDLE);
    assign bus.t_bsy_oe_n = ~q.bsy;
    assign bus.t_sel_oe_n = 1'b1;
    assign bus.t_cd_oe_n  = ~(own & i_phase[1]);
    assign bus.t_io_oe_n  = ~(own & i_phase[0]);
    assign bus.t_msg_oe_n = ~(own & i_phase[2]);
    assign bus.t_req_oe_n = ~q.req;
    assign bus.t_rst_oe_n = 1'b1;
    assign bus.t_db_oe_n  = (own && to_init && q.req) ? ~q.dout : 8'hFF;
    assign bus.t_dbp_oe_n = ~(own && to_init && q.req && odd_par(q.dout));

    // ------------------------------------------------------------
    // User outputs
    // ------------------------------------------------------------
    assign o_tx_ready   = q.tx_ready;
    assign o_rx_data    = q.buf0;
    assign o_rx_valid   = q.rx_v;
    assign o_rx_par_err = q.par_err;
    assign o_selected   = q.bsy;
    assign o_atn        = b_atn;
    assign o_bus_rst    = b_rst;
    assign o_bus_busy   = b_bsy;
endmodule

/* verif/scsi_target_bus_signals_test.sv */
// Purpose: Self-checking bench joining target and initiator ends
// Assumes: Inputs change on the falling clock edge
// Notes:   Target id 5, initiator id 7
`timescale 1ns/1ps
module scsi_target_bus_signals_test;
    typedef logic [7:0] stbs_b_t;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    stbs_pkg::stbs_phase_t t_phase = 3'h1;
    logic                 t_conn = 1'b0;
    stbs_b_t              t_txd = 8'h00;
    logic                 t_txv = 1'b0;
    logic                 t_txr;
    stbs_b_t              t_rxd;
    logic                 t_rxv;
    logic                 t_rxr = 1'b0;
    logic                 t_perr;
    logic                 t_sel;
    logic                 t_atn;
    logic                 t_brst;
    logic                 t_busy;
    logic                 n_sel = 1'b0;
    logic                 n_atn = 1'b0;
    logic                 n_brst = 1'b0;
    stbs_b_t              n_txd = 8'h00;
    logic                 n_txr;
    stbs_b_t              n_rxd;
    logic                 n_rxv;
    logic                 n_perr;
    logic                 n_conn;
    stbs_b_t              in_q[$];
    stbs_b_t              out_q[$];
    stbs_b_t              pat[4] = '{8'h00, 8'hFF, 8'hA5, 8'h01};
    int                   pulses = 0;
    int                   errors = 0;
    int                   check_count = 0;
    int                   k;

    stbs_bus_if bus ();
    stbs_target stbs_target_i (.i_core_clk(clk), .i_rst_n(rst_n),
        .bus(bus), .i_phase(t_phase), .i_connect(t_conn),
        .i_tx_data(t_txd), .i_tx_valid(t_txv), .o_tx_ready(t_txr),
        .o_rx_data(t_rxd), .o_rx_valid(t_rxv), .i_rx_ready(t_rxr),
        .o_rx_par_err(t_perr), .o_selected(t_sel), .o_atn(t_atn),
        .o_bus_rst(t_brst), .o_bus_busy(t_busy));
    stbs_initiator stbs_initiator_i (.i_core_clk(clk), .i_rst_n(rst_n),
        .bus(bus), .i_select(n_sel), .i_target_id(3'h5), .i_atn(n_atn),
        .i_bus_reset(n_brst), .i_tx_data(n_txd), .o_tx_ready(n_txr),
        .o_rx_data(n_rxd), .o_rx_valid(n_rxv), .o_rx_par_err(n_perr),
        .o_connected(n_conn));
    stbs_bus_chk #(.TGT_ID(5)) stbs_bus_chk_i (.i_core_clk(clk),
        .i_rst_n(rst_n), .t_bsy_oe_n(bus.t_bsy_oe_n),
        .t_msg_oe_n(bus.t_msg_oe_n), .t_req_oe_n(bus.t_req_oe_n),
        .bsy_n(bus.bsy_n), .sel_n(bus.sel_n), .req_n(bus.req_n),
        .ack_n(bus.ack_n), .rst_n(bus.rst_n), .db_n(bus.db_n),
        .dbp_n(bus.dbp_n));

    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (n_rxv === 1'b1) in_q.push_back(n_rxd);
        if (t_rxv === 1'b1 && t_rxr === 1'b1) out_q.push_back(t_rxd);
        if (n_txr === 1'b1) pulses++;
    end

    task automatic check(string nm, stbs_b_t e, stbs_b_t g);
        check_count++;
        if (g !== e) begin
            $display("Error %s exp %h got %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic close_out();
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic test_select();
        t_conn = 1'b1;
        n_sel = 1'b1;
        for (k = 0; k < 50 && bus.sel_n !== 1'b0; k++) tick(1);
        check("db_n", 8'h5F, bus.db_n);
        for (k = 0; k < 50 && n_conn !== 1'b1; k++) tick(1);
        tick(4);
        check("sel", 8'h01, 8'(t_sel));
        check("busy", 8'h01, 8'(t_busy));
    endtask

    task automatic test_data_in();
        t_phase = 3'h1;
        t_txv = 1'b1;
        foreach (pat[i]) begin
            t_txd = pat[i];
            for (k = 0; k < 100 && t_txr !== 1'b1; k++) tick(1);
            tick(1);
        end
        t_txv = 1'b0;
        for (k = 0; k < 200 && in_q.size() < 4; k++) tick(1);
        tick(10);
        check("in_n", 8'h04, 8'(in_q.size()));
        foreach (in_q[i]) check("in", pat[i], in_q[i]);
        check("n_perr", 8'h00, 8'(n_perr));
    endtask

    task automatic test_data_out();
        t_phase = 3'h0;
        pulses = 0;
        for (int j = 0; j < 3; j++) begin
            n_txd = pat[j + 1];
            for (k = 0; k < 100 && pulses <= j; k++) tick(1);
            if (j == 1) tick(40);
            if (j == 1) check("full", 8'h02, 8'(pulses));
            if (j == 1) check("rxv", 8'h01, 8'(t_rxv));
            if (j == 1) t_rxr = 1'b1;
        end
        for (k = 0; k < 200 && out_q.size() < 3; k++) tick(1);
        check("out_n", 8'h03, 8'(out_q.size()));
        foreach (out_q[i]) check("out", pat[i + 1], out_q[i]);
        check("t_perr", 8'h00, 8'(t_perr));
    endtask

    task automatic test_lines();
        n_atn = 1'b1;
        tick(1);
        check("atn_early", 8'h00, 8'(t_atn));
        tick(3);
        check("atn", 8'h01, 8'(t_atn));
        check("atn_n", 8'h00, 8'(bus.atn_n));
        n_atn = 1'b0;
        t_phase = 3'h4;
        tick(4);
        check("msg_n", 8'h00, 8'(bus.msg_n));
        t_phase = 3'h2;
        tick(4);
        check("cd_n", 8'h00, 8'(bus.cd_n));
        check("msg_off", 8'h01, 8'(bus.msg_n));
    endtask

    task automatic test_bus_reset();
        t_rxr = 1'b0;
        tick(40);
        n_sel = 1'b0;
        n_brst = 1'b1;
        tick(6);
        check("brst", 8'h01, 8'(t_brst));
        check("rst_n", 8'h00, 8'(bus.rst_n));
        n_brst = 1'b0;
        t_conn = 1'b0;
        tick(6);
        check("t_sel", 8'h00, 8'(t_sel));
        check("n_conn", 8'h00, 8'(n_conn));
        check("bsy_n", 8'h01, 8'(bus.bsy_n));
        check("t_busy", 8'h00, 8'(t_busy));
    endtask

    initial begin
        tick(16);
        rst_n = 1'b1;
        tick(2);
        test_select();
        test_data_in();
        test_data_out();
        test_lines();
        test_bus_reset();
        close_out();
    end

    // Tests need about 200 cycles; the watchdog allows far more
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule

/* verif/stbs_bus_chk.sv */
// Purpose: Checks on the shared wires between the two bus ends
// Assumes: One clock domain; a line low means asserted
// Notes:   Instantiated beside the interface, no bind
`timescale 1ns/1ps
module stbs_bus_chk #(
    parameter int TGT_ID = 5
) (
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    input wire logic       t_bsy_oe_n,
    input wire logic       t_msg_oe_n,
    input wire logic       t_req_oe_n,
    input wire logic       bsy_n,
    input wire logic       sel_n,
    input wire logic       req_n,
    input wire logic       ack_n,
    input wire logic       rst_n,
    input wire logic [7:0] db_n,
    input wire logic       dbp_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_req_up; $fell(req_n); endsequence
    sequence s_ack_answer; ##[1:10] !ack_n; endsequence
    property p_ack_follows; s_req_up |-> s_ack_answer; endproperty
    property p_req_free; s_req_up |-> ack_n; endproperty
    property p_req_holds; (!req_n && ack_n) |=> !req_n; endproperty
    property p_ack_holds; (!ack_n && !req_n) |=> !ack_n; endproperty
    property p_parity; $fell(ack_n) |-> ^(~{dbp_n, db_n}); endproperty
    property p_msg_owner; !t_msg_oe_n |-> !bsy_n; endproperty
    property p_sel_bit;
        $fell(t_bsy_oe_n) |-> (!sel_n && !db_n[TGT_ID]);
    endproperty
    property p_rst_free;
        $fell(rst_n) |-> ##[1:6] (t_bsy_oe_n && t_req_oe_n);
    endproperty
    a_ack_follows: assert property (p_ack_follows)
        else $error("no acknowledge after request");
    a_req_free: assert property (p_req_free)
        else $error("request while acknowledge held");
    a_req_holds: assert property (p_req_holds)
        else $error("request dropped before acknowledge");
    a_ack_holds: assert property (p_ack_holds)
        else $error("acknowledge dropped before request");
    a_parity: assert property (p_parity)
        else $error("even parity on data bus");
    a_msg_owner: assert property (p_msg_owner)
        else $error("message line without bus ownership");
    a_sel_bit: assert property (p_sel_bit)
        else $error("busy taken without own select bit");
    a_rst_free: assert property (p_rst_free)
        else $error("drivers held after bus reset");
endmodule
